/* File: hdl/ckmr_pkg.sv */
/*
  Constants for the clock, strap-mode and reset control block.
  Assumes one 50 MHz master clock samples every clock and strap input.
*/
package ckmr_pkg;
  // =====================================================
  // master clock and rate limits
  localparam int CLK_FREQ_MHZ = 50;
  localparam int DISP_MAX_MHZ = 33;
  localparam int OP_DISP_RATIO = 2;
  // shortest legal display period in master cycles, rounded up
  localparam int DISP_MIN_PER_CYC = (CLK_FREQ_MHZ + DISP_MAX_MHZ - 1) / DISP_MAX_MHZ;

  // =====================================================
  // strap codes as {hi, mid, lo}
  localparam int STRAP_W = 3;
  localparam logic [STRAP_W-1:0] STRAP_X1 = 3'h0;
  localparam logic [STRAP_W-1:0] STRAP_X2 = 3'h1;
  localparam logic [STRAP_W-1:0] STRAP_X4 = 3'h2;

  // =====================================================
  // multiplier as a shift count
  localparam int SHIFT_W = 2;
  localparam logic [SHIFT_W-1:0] SHIFT_X1 = 2'h0;
  localparam logic [SHIFT_W-1:0] SHIFT_X2 = 2'h1;
  localparam logic [SHIFT_W-1:0] SHIFT_X4 = 2'h2;

  // =====================================================
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_MEASURE = 4'h2,
    ST_RUN = 4'h4,
    ST_HALT = 4'h8
  } ckmr_state_e;
endpackage

/* File: hdl/ckmr_edge_meas.sv */
/*
  Synchroniser, rising-edge detector and period counter for one clock input.
  Assumes the input toggles slower than half the master clock rate.
*/
module ckmr_edge_meas
  import ckmr_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic CLOCK, // master clock
  input wire logic SRST, // synchronous reset, high
  input wire logic SIG_IN, // raw clock input
  output logic LEVEL, // synchronised level
  output logic RISE, // one-cycle pulse on rising edge
  output logic [CNT_W-1:0] PERIOD, // last period in master cycles
  output logic VALID // two edges seen, period usable
);
  logic sync1_r;
  logic sync2_r;
  logic last_r;
  logic seen_r;
  logic [CNT_W-1:0] cnt_r;
  logic rise_w;

  // elaboration-time refusal of unusable widths
  if (CNT_W < 4)
  begin : g_cnt_w_check
    $error("ckmr_edge_meas: CNT_W too small");
  end

  // =====================================================
  // two-flop synchroniser, edge taken after second stage
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      last_r <= 1'b0;
    end
    else
    begin
      sync1_r <= SIG_IN;
      sync2_r <= sync1_r;
      last_r <= sync2_r;
    end
  end

  assign rise_w = sync2_r & ~last_r;

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      RISE <= 1'b0;
    else
      RISE <= rise_w;
  end

  assign LEVEL = last_r;

  // =====================================================
  // period counter, saturating
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      cnt_r <= '0;
      PERIOD <= '0;
      seen_r <= 1'b0;
      VALID <= 1'b0;
    end
    else if (rise_w)
    begin
      cnt_r <= CNT_W'(1);
      PERIOD <= cnt_r;
      seen_r <= 1'b1;
      VALID <= seen_r;
    end
    else if (cnt_r != '1)
      cnt_r <= cnt_r + CNT_W'(1);
  end
endmodule

/* File: hdl/ckmr_top.sv */
/*
  Clock, strap-mode and reset control: latches the mode straps, rebuilds the
  operating clock at x1/x2/x4 of the system clock input with 50% duty, forwards
  the display clock and releases core and display resets.
  Assumes all inputs are sampled by the 50 MHz master clock.
*/
// Overview of operation
// R01 - straps captured during reset, frozen after release until next reset
// R02 - straps all low: operating clock equals system clock input frequency
// R03 - only lowest strap high: operating clock twice the input frequency
// R04 - only middle strap high: four times; other codes prohibited, block halts
// R05 - operating clock derived from system input at chosen multiple, 50% duty
// R06 - board supplies system clock and independent display clock on two inputs
// R07 - core and graphics memory timing run from the operating clock
// R08 - dot clock, pixel output and sync timing run from the display clock
// R09 - operating clock at least twice display clock; display at most 33 MHz
// R10 - low reset input holds hardware reset, pins and registers initialised
// R11 - display and operating domains asynchronous; crossings are synchronised
module ckmr_top
  import ckmr_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic CLOCK, // 50 MHz master clock
  input wire logic SRST, // synchronous reset, high
  input wire logic RESET_N, // hardware reset pin, low
  input wire logic STRAP_SEL_LO, // mode strap, low bit
  input wire logic STRAP_SEL_MID, // mode strap, middle bit
  input wire logic STRAP_SEL_HI, // mode strap, high bit
  input wire logic SYS_CLK_IN, // system base clock input
  input wire logic DISP_CLK_IN, // display clock input
  output logic OP_CLK, // rebuilt operating clock level
  output logic OP_CLK_EN, // pulse per operating clock rise
  output logic DOT_CLK, // display dot clock level
  output logic DOT_CLK_EN, // pulse per display clock rise
  output logic CORE_RST, // core and memory logic reset
  output logic DISP_RST, // display logic reset
  output logic PIN_INIT, // pins forced to initial state
  output logic [SHIFT_W-1:0] MULT_SEL, // latched multiplier shift
  output logic STRAP_ERR, // prohibited strap code latched
  output logic CLK_LOCK, // operating clock running
  output logic RATE_ERR // clock ratio or display rate out of range
);
  logic hw_rst;
  logic [STRAP_W-1:0] strap_r;
  logic [SHIFT_W-1:0] shift_nxt;
  logic strap_bad;
  ckmr_state_e state_r;
  ckmr_state_e state_nxt;
  logic sys_rise;
  logic sys_valid;
  logic [CNT_W-1:0] sys_period;
  logic disp_level;
  logic disp_rise;
  logic disp_valid;
  logic [CNT_W-1:0] disp_period;
  logic [CNT_W-1:0] half_raw;
  logic [CNT_W-1:0] half_per;
  logic [CNT_W-1:0] ph_cnt_r;
  logic op_clk_r;
  logic op_go_r;
  logic [1:0] disp_rst_r;
  logic [CNT_W+1:0] op_per_x;

  // elaboration-time refusal of unusable widths
  if (CNT_W < 4 || CNT_W > 30)
  begin : g_cnt_w_check
    $error("ckmr_top: CNT_W out of range");
  end

  assign hw_rst = SRST | ~RESET_N; // [R10]

  // =====================================================
  // strap capture
  always_ff @(posedge CLOCK)
  begin
    if (hw_rst)
      strap_r <= {STRAP_SEL_HI, STRAP_SEL_MID, STRAP_SEL_LO}; // [R01]
  end

  always_comb
  begin
    shift_nxt = SHIFT_X1;
    strap_bad = 1'b0;
    case (strap_r)
      STRAP_X1: shift_nxt = SHIFT_X1; // [R02]
      STRAP_X2: shift_nxt = SHIFT_X2; // [R03]
      STRAP_X4: shift_nxt = SHIFT_X4; // [R04]
      default: strap_bad = 1'b1; // [R04]
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (hw_rst)
    begin
      MULT_SEL <= SHIFT_X1;
      STRAP_ERR <= 1'b0;
    end
    else if (state_r == ST_RESET)
    begin
      MULT_SEL <= shift_nxt;
      STRAP_ERR <= strap_bad;
    end
  end

  // =====================================================
  // input clock measurement
  ckmr_edge_meas #(.CNT_W(CNT_W)) u_sys_meas (
    .CLOCK(CLOCK),
    .SRST(hw_rst),
    .SIG_IN(SYS_CLK_IN),
    .LEVEL(),
    .RISE(sys_rise),
    .PERIOD(sys_period),
    .VALID(sys_valid)
  );

  ckmr_edge_meas #(.CNT_W(CNT_W)) u_disp_meas (
    .CLOCK(CLOCK),
    .SRST(hw_rst),
    .SIG_IN(DISP_CLK_IN),
    .LEVEL(disp_level),
    .RISE(disp_rise),
    .PERIOD(disp_period),
    .VALID(disp_valid)
  );

  // =====================================================
  // sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET: state_nxt = strap_bad ? ST_HALT : ST_MEASURE;
      ST_MEASURE:
        if (sys_valid)
          state_nxt = ST_RUN;
      ST_RUN: state_nxt = ST_RUN;
      ST_HALT: state_nxt = ST_HALT; // prohibited code: wait for reset
      default: state_nxt = ST_RESET;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (hw_rst)
      state_r <= ST_RESET; // [R10]
    else
      state_r <= state_nxt;
  end

  // =====================================================
  // operating clock rebuild, half period = input period / (2 * multiple)
  assign half_raw = sys_period >> (MULT_SEL + SHIFT_W'(1)); // [R05]
  assign half_per = (half_raw == '0) ? CNT_W'(1) : half_raw;

  always_ff @(posedge CLOCK)
  begin
    if (hw_rst || state_r != ST_RUN)
    begin
      op_clk_r <= 1'b0;
      op_go_r <= 1'b0;
      ph_cnt_r <= '0;
      OP_CLK_EN <= 1'b0;
    end
    else if (sys_rise)
    begin
      // realign phase to each input rise to stop drift
      op_clk_r <= 1'b1; // [R05]
      op_go_r <= 1'b1;
      ph_cnt_r <= '0;
      OP_CLK_EN <= ~op_clk_r; // [R07]
    end
    // stay low until the first input rise, else the first high phase stretches
    else if (op_go_r && ph_cnt_r >= half_per - CNT_W'(1)) // [R05]
    begin
      op_clk_r <= ~op_clk_r; // [R05]
      ph_cnt_r <= '0;
      OP_CLK_EN <= ~op_clk_r; // [R07]
    end
    else
    begin
      ph_cnt_r <= ph_cnt_r + CNT_W'(1);
      OP_CLK_EN <= 1'b0;
    end
  end

  assign OP_CLK = op_clk_r;

  // =====================================================
  // display clock forwarding and display reset crossing
  always_ff @(posedge CLOCK)
  begin
    if (hw_rst)
    begin
      DOT_CLK <= 1'b0;
      DOT_CLK_EN <= 1'b0;
    end
    else
    begin
      DOT_CLK <= disp_level; // [R08]
      DOT_CLK_EN <= disp_rise; // [R08]
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (hw_rst)
      disp_rst_r <= 2'h3;
    else if (disp_rise)
      disp_rst_r <= {disp_rst_r[0], CORE_RST}; // [R11]
  end

  assign DISP_RST = disp_rst_r[1];

  // =====================================================
  // core reset, lock and rate checks
  always_ff @(posedge CLOCK)
  begin
    if (hw_rst)
    begin
      CORE_RST <= 1'b1; // [R10]
      PIN_INIT <= 1'b1; // [R10]
      CLK_LOCK <= 1'b0;
    end
    else
    begin
      CORE_RST <= (state_nxt != ST_RUN); // [R07]
      PIN_INIT <= (state_nxt != ST_RUN);
      CLK_LOCK <= (state_nxt == ST_RUN);
    end
  end

  assign op_per_x = {1'b0, half_per, 1'b0} * (CNT_W+2)'(OP_DISP_RATIO);

  always_ff @(posedge CLOCK)
  begin
    if (hw_rst || state_r != ST_RUN || !disp_valid)
      RATE_ERR <= 1'b0;
    else
      RATE_ERR <= (disp_period < CNT_W'(DISP_MIN_PER_CYC))
        || (op_per_x > {2'h0, disp_period}); // [R09] [R06]
  end
endmodule

/* File: dv/ckmr_top_properties.sv */
/*
  Port checker for the clock, strap-mode and reset control block.
  Assumes it is bound to ckmr_top and clocked by its master clock.
*/
module ckmr_top_properties
  import ckmr_pkg::*;
(
  input wire logic CLOCK, // clk
  input wire logic SRST, // rst
  input wire logic RESET_N, // pin rst
  input wire logic STRAP_SEL_LO, // strap
  input wire logic STRAP_SEL_MID, // strap
  input wire logic STRAP_SEL_HI, // strap
  input wire logic OP_CLK, // op clk
  input wire logic OP_CLK_EN, // op rise
  input wire logic DOT_CLK_EN, // dot rise
  input wire logic CORE_RST, // core rst
  input wire logic DISP_RST, // disp rst
  input wire logic PIN_INIT, // pin init
  input wire logic [SHIFT_W-1:0] MULT_SEL, // mult
  input wire logic STRAP_ERR // bad code
);
  logic [2:0] code_r;
  // ==========
  // strap code last seen in reset
  always_ff @(posedge CLOCK)
  begin
    if (SRST || !RESET_N)
      code_r <= {STRAP_SEL_HI, STRAP_SEL_MID, STRAP_SEL_LO};
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SRST);
  sequence rel_s;
    !RESET_N ##1 RESET_N [*2];
  endsequence
  // ==========
  // properties
  rst_vals_a: assert property (!RESET_N |=>
    CORE_RST && DISP_RST && !OP_CLK && !STRAP_ERR && MULT_SEL == 2'h0)
    else $error("reset state wrong");
  pin_init_a: assert property (PIN_INIT == CORE_RST)
    else $error("pin init differs");
  mult_frz_a: assert property (RESET_N [*3] |=> $stable(MULT_SEL) && $stable(STRAP_ERR))
    else $error("mode changed");
  strap_code_a: assert property (rel_s |=> STRAP_ERR == (code_r > 3'h2) &&
    (STRAP_ERR || MULT_SEL == code_r[1:0])) else $error("mode decode wrong");
  err_hold_a: assert property (STRAP_ERR |-> CORE_RST && !OP_CLK)
    else $error("runs on bad code");
  op_rise_a: assert property (OP_CLK_EN == $rose(OP_CLK))
    else $error("op pulse wrong");
  dot_pulse_a: assert property (DOT_CLK_EN |=> !DOT_CLK_EN)
    else $error("dot pulse long");
  rst_order_a: assert property (CORE_RST |-> DISP_RST)
    else $error("display out first");
endmodule

bind ckmr_top ckmr_top_properties u_ckmr_top_properties (.CLOCK, .SRST, .RESET_N, .STRAP_SEL_LO,
  .STRAP_SEL_MID, .STRAP_SEL_HI, .OP_CLK, .OP_CLK_EN, .DOT_CLK_EN, .CORE_RST, .DISP_RST,
  .PIN_INIT, .MULT_SEL, .STRAP_ERR);

/* File: dv/ckmr_board.sv */
/*
  Board model: free-running system and display clock sources.
  Assumes the bench sets each half period in ns.
*/
module ckmr_board
(
  input wire logic [15:0] sys_half, // ns
  input wire logic [15:0] disp_half, // ns
  output logic sys_clk, // base clock
  output logic disp_clk // display clock
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // two unrelated sources
  initial
  begin
    sys_clk = 1'b0;
    #3;
    forever #(sys_half) sys_clk = ~sys_clk;
  end
  initial
  begin
    disp_clk = 1'b0;
    #37;
    forever #(disp_half) disp_clk = ~disp_clk;
  end
endmodule

/* File: dv/ckmr_top_bench.sv */
/*
  Self-checking bench for the clock, strap-mode and reset control block.
  Assumes the board model drives both clock inputs.
*/
module ckmr_top_bench
  import ckmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, srst, reset_n, s_lo, s_mid, s_hi, sys_clk, disp_clk, op_clk, op_en, dot_clk;
  logic dot_en, core_rst, disp_rst, pin_init, strap_err, clk_lock, rate_err;
  logic [SHIFT_W-1:0] mult_sel;
  logic [15:0] sys_half, disp_half;
  int mismatches, n_compared;
  ckmr_board u_ckmr_board (.sys_half, .disp_half, .sys_clk, .disp_clk);
  ckmr_top u_ckmr_top (.CLOCK(clock), .SRST(srst), .RESET_N(reset_n), .STRAP_SEL_LO(s_lo),
    .STRAP_SEL_MID(s_mid), .STRAP_SEL_HI(s_hi), .SYS_CLK_IN(sys_clk), .DISP_CLK_IN(disp_clk),
    .OP_CLK(op_clk), .OP_CLK_EN(op_en), .DOT_CLK(dot_clk), .DOT_CLK_EN(dot_en),
    .CORE_RST(core_rst), .DISP_RST(disp_rst), .PIN_INIT(pin_init), .MULT_SEL(mult_sel),
    .STRAP_ERR(strap_err), .CLK_LOCK(clk_lock), .RATE_ERR(rate_err));
  // ==========
  // helpers
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wait_for(input string what, ref logic sig, input logic lvl);
    int n;
    n = 0;
    while (sig !== lvl)
    begin
      @(negedge clock);
      n++;
      if (n > 400)
      begin
        check(what, sig, lvl);
        finish_test();
      end
    end
  endtask
  task automatic span(ref logic sig, input logic lvl, output logic [7:0] n);
    n = 8'h00;
    while (sig === lvl && n < 8'h40)
    begin
      @(negedge clock);
      n++;
    end
  endtask
  // straps wrong early in reset, moved again after release
  task automatic hw_reset(input logic [2:0] code);
    reset_n = 1'b0;
    {s_hi, s_mid, s_lo} = ~code;
    repeat (5) @(negedge clock);
    {s_hi, s_mid, s_lo} = code;
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    {s_hi, s_mid, s_lo} = ~code;
  endtask
  // ==========
  // scenarios
  task automatic test_mode(input logic [2:0] code, input logic [1:0] shift, input logic [7:0] h);
    logic [7:0] hi, lo;
    hw_reset(code);
    check("mult_sel", mult_sel, shift);
    check("strap_err", strap_err, 1'b0);
    wait_for("core_rst", core_rst, 1'b0);
    check("pin_init", pin_init, 1'b0);
    check("clk_lock", clk_lock, 1'b1);
    wait_for("op_clk", op_clk, 1'b0);
    wait_for("op_clk", op_clk, 1'b1);
    span(op_clk, 1'b1, hi);
    span(op_clk, 1'b0, lo);
    check("op_high", hi, h);
    check("op_low", lo, h);
    wait_for("disp_rst", disp_rst, 1'b0);
    repeat (60) @(negedge clock);
    check("rate_err", rate_err, 1'b0);
    check("mult_hold", mult_sel, shift);
    $display("mode %0h done", code);
  endtask
  task automatic test_rate();
    int n;
    int m;
    logic prev;
    disp_half = 16'h46;
    hw_reset(STRAP_X1);
    wait_for("core_rst", core_rst, 1'b0);
    repeat (60) @(negedge clock);
    check("rate_err", rate_err, 1'b1);
    n = 0;
    m = 0;
    prev = dot_clk;
    repeat (140)
    begin
      @(negedge clock);
      n += (dot_en === 1'b1);
      m += (dot_clk === 1'b1 && prev === 1'b0);
      prev = dot_clk;
    end
    check("dot_count", 8'(n), 8'h14);
    check("dot_level", 8'(m), 8'h14);
    disp_half = 16'hAA;
    $display("rate test done");
  endtask
  task automatic test_bad();
    int seen;
    for (int c = 3; c < 8; c++)
    begin
      hw_reset(3'(c));
      seen = 0;
      repeat (60)
      begin
        @(negedge clock);
        seen += (op_clk !== 1'b0);
      end
      check("strap_err", strap_err, 1'b1);
      check("core_rst", core_rst, 1'b1);
      check("clk_lock", clk_lock, 1'b0);
      check("op_clk", 8'(seen), 8'h00);
    end
    $display("prohibited codes done");
  endtask
  // ==========
  // main sequence
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial
  begin
    srst = 1'b1;
    reset_n = 1'b1;
    {s_hi, s_mid, s_lo} = 3'h0;
    sys_half = 16'h50;
    disp_half = 16'hAA;
    mismatches = 0;
    n_compared = 0;
    repeat (20) @(negedge clock);
    srst = 1'b0;
    test_mode(STRAP_X1, SHIFT_X1, 8'h04);
    test_mode(STRAP_X2, SHIFT_X2, 8'h02);
    test_mode(STRAP_X4, SHIFT_X4, 8'h01);
    test_rate();
    test_bad();
    finish_test();
  end
endmodule
